/* src/stb_trace_access.sv */
/*
 * Section trace status, change flags, interrupt and paged indirect buffer access.
 * Assumes host strobes and the receive byte stream are synchronous to mclk;
 * rx.msgEnd is a separate pulse after the last byte of each message.
 */
// Function
// - mismatch bit shows accepted versus expected difference
// - mismatch toggle sets flag; status read clears
// - unstable after eight consecutive differing messages
// - unstable clears when message gets accepted
// - unstable toggle sets flag; status read clears
// - busy bit 7 set by address write
// - address register holds select plus index
// - receive side maps capture and expected pages
// - capture from stream, expected from host
// - transmit side maps transmit J0 buffer
// - select high reads buffer into data
// - select low writes data into buffer
// - data register eight bits, reset zero
// - control bit steers receive or transmit
// - enable bits gate interrupt per flag
// - accept after five or three receptions
`default_nettype none

module stb_trace_access (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Host register port
  input wire stb_pkg::stb_bus_s bus,
  output logic [7:0] regRdData,
  // Receive trace stream
  input wire stb_pkg::stb_rx_s rx,
  // Transmit J0 insertion
  input wire logic txJ0Req,
  output logic [7:0] txJ0Byte,
  // Interrupt
  output logic irq_out_n
);

  // ************************************************
  // State
  // ************************************************
  stb_pkg::stb_state_s s_r;
  stb_pkg::stb_state_s s_nxt;
  logic stRd;
  logic accessEvt;
  logic acceptEvt;
  logic mmEvt;
  logic unEvt;
  logic [2:0] need;
  logic [5:0] idx;

  assign stRd = bus.rd && bus.addr == stb_pkg::STAT_ADDR;
  assign need = s_r.ctl[stb_pkg::CTL_PERS] ? stb_pkg::PERSIST_LONG : stb_pkg::PERSIST_SHORT;
  assign idx = s_r.iaddr[5:0];

  always_comb begin
    s_nxt = s_r;
    accessEvt = 1'b0;
    acceptEvt = 1'b0;

    // ************************************************
    // Register writes
    // ************************************************
    if (bus.wr) begin
      case (bus.addr)
        stb_pkg::CTL_ADDR: s_nxt.ctl = bus.wdata[6:0];
        stb_pkg::IDATA_ADDR: s_nxt.idata = bus.wdata;
        stb_pkg::IADDR_ADDR: begin
          s_nxt.iaddr = bus.wdata;
          s_nxt.busy = 1'b1;
          s_nxt.state = stb_pkg::STB_ACC;
        end
        default: ;
      endcase
    end

    // ************************************************
    // Indirect access, one cycle after the launch
    // ************************************************
    case (s_r.state)
      stb_pkg::STB_IDLE: ;
      stb_pkg::STB_ACC: begin
        if (!(bus.wr && bus.addr == stb_pkg::IADDR_ADDR)) begin
          s_nxt.busy = 1'b0;
          s_nxt.state = stb_pkg::STB_IDLE;
        end
        accessEvt = 1'b1;
        if (s_r.iaddr[stb_pkg::IA_RW]) begin
          // Transmit side upper half is unused and reads as zero
          if (s_r.ctl[stb_pkg::CTL_RXSEL]) begin
            s_nxt.idata = s_r.iaddr[stb_pkg::IA_PAGE] ? s_r.exp[idx] : s_r.cap[idx];
          end else begin
            s_nxt.idata = s_r.iaddr[stb_pkg::IA_PAGE] ? 8'h00 : s_r.tx[idx];
          end
        end else if (s_r.ctl[stb_pkg::CTL_RXSEL]) begin
          if (s_r.iaddr[stb_pkg::IA_PAGE]) begin
            s_nxt.exp[idx] = s_r.idata;
          end else begin
            s_nxt.cap[idx] = s_r.idata;
          end
        end else if (!s_r.iaddr[stb_pkg::IA_PAGE]) begin
          s_nxt.tx[idx] = s_r.idata;
        end
      end
      default: begin
        s_nxt.state = stb_pkg::STB_IDLE;
        s_nxt.busy = 1'b0;
      end
    endcase

    // ************************************************
    // Receive trace capture and message evaluation
    // ************************************************
    if (rx.valid) begin
      if (rx.data != s_r.cap[s_r.capIdx]) begin
        s_nxt.curSame = 1'b0;
      end
      if (rx.data != s_r.exp[s_r.capIdx]) begin
        s_nxt.curExp = 1'b0;
      end
      s_nxt.cap[s_r.capIdx] = rx.data;
      s_nxt.capIdx = s_r.capIdx + 6'h01;
    end else if (rx.msgEnd) begin
      s_nxt.capIdx = 6'h00;
      s_nxt.curSame = 1'b1;
      s_nxt.curExp = 1'b1;
      if (s_r.curSame) begin
        s_nxt.diffCnt = 4'h0;
        if (s_r.sameCnt < stb_pkg::PERSIST_LONG) begin
          s_nxt.sameCnt = s_r.sameCnt + 3'h1;
        end
        if (s_r.sameCnt + 3'h1 >= need) begin
          acceptEvt = 1'b1;
          s_nxt.mm = !s_r.curExp;
          s_nxt.un = 1'b0;
        end
      end else begin
        s_nxt.sameCnt = 3'h1;
        if (s_r.diffCnt < stb_pkg::UNSTABLE_COUNT) begin
          s_nxt.diffCnt = s_r.diffCnt + 4'h1;
        end
        if (s_r.diffCnt + 4'h1 >= stb_pkg::UNSTABLE_COUNT) begin
          s_nxt.un = 1'b1;
        end
      end
    end

    // ************************************************
    // Change flags: a new change beats the read clear
    // ************************************************
    mmEvt = s_nxt.mm != s_r.mm;
    unEvt = s_nxt.un != s_r.un;
    s_nxt.mmFlag = (s_r.mmFlag && !stRd) || mmEvt;
    s_nxt.unFlag = (s_r.unFlag && !stRd) || unEvt;

    // ************************************************
    // Register read data
    // ************************************************
    if (bus.rd) begin
      case (bus.addr)
        stb_pkg::CTL_ADDR: s_nxt.rdData = {1'b0, s_r.ctl};
        stb_pkg::STAT_ADDR: s_nxt.rdData = {s_r.busy, 3'h0, s_r.unFlag, s_r.un, s_r.mmFlag, s_r.mm};
        stb_pkg::IADDR_ADDR: s_nxt.rdData = s_r.iaddr;
        stb_pkg::IDATA_ADDR: s_nxt.rdData = s_r.idata;
        default: s_nxt.rdData = 8'h00;
      endcase
    end

    // ************************************************
    // Transmit J0 byte insertion
    // ************************************************
    if (txJ0Req) begin
      s_nxt.txByte = s_r.ctl[stb_pkg::CTL_TNULL] ? 8'h00 : s_r.tx[s_r.txIdx];
      if (s_r.ctl[stb_pkg::CTL_LEN16] && s_r.txIdx == stb_pkg::SHORT_MSG_LAST) begin
        s_nxt.txIdx = 6'h00;
      end else begin
        s_nxt.txIdx = s_r.txIdx + 6'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
      s_r.state <= stb_pkg::STB_IDLE;
      s_r.ctl <= stb_pkg::CTL_RESET;
      s_r.iaddr <= stb_pkg::IADDR_RESET;
      s_r.idata <= stb_pkg::IDATA_RESET;
      s_r.curSame <= 1'b1;
      s_r.curExp <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ************************************************
  // Outputs
  // ************************************************
  assign regRdData = s_r.rdData;
  assign txJ0Byte = s_r.txByte;
  assign irq_out_n = !((s_r.mmFlag && s_r.ctl[stb_pkg::CTL_MMIE]) ||
                       (s_r.unFlag && s_r.ctl[stb_pkg::CTL_UNIE]));

  // ************************************************
  // Assertions
  // ************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  busy_on_launch_a: assert property (
    bus.wr && bus.addr == stb_pkg::IADDR_ADDR |=> s_r.busy && s_r.state == stb_pkg::STB_ACC)
    else $error("busy not raised by address write");

  busy_one_cycle_a: assert property (
    s_r.busy && !(bus.wr && bus.addr == stb_pkg::IADDR_ADDR) |=> !s_r.busy)
    else $error("busy did not clear after access");

  mm_flag_set_a: assert property (
    $changed(s_r.mm) |-> s_r.mmFlag)
    else $error("mismatch change did not set flag");

  un_flag_set_a: assert property (
    $changed(s_r.un) |-> s_r.unFlag)
    else $error("unstable change did not set flag");

  stat_rd_clear_a: assert property (
    stRd && !mmEvt && !unEvt |=> !s_r.mmFlag && !s_r.unFlag)
    else $error("status read did not clear flags");

  irq_follow_a: assert property (
    s_r.mmFlag && s_r.ctl[stb_pkg::CTL_MMIE] |-> !irq_out_n)
    else $error("interrupt not asserted for enabled flag");

  accept_stable_a: assert property (
    acceptEvt |=> !s_r.un && s_r.sameCnt >= need)
    else $error("unstable not cleared on acceptance");

  rd_access_a: assert property (
    s_r.state == stb_pkg::STB_ACC && s_r.iaddr[stb_pkg::IA_RW] && s_r.ctl[stb_pkg::CTL_RXSEL]
      && !s_r.iaddr[stb_pkg::IA_PAGE] |=> s_r.idata == $past(s_r.cap[idx]))
    else $error("indirect read returned wrong byte");

  wr_access_a: assert property (
    s_r.state == stb_pkg::STB_ACC && !s_r.iaddr[stb_pkg::IA_RW] && !s_r.ctl[stb_pkg::CTL_RXSEL]
      && !s_r.iaddr[stb_pkg::IA_PAGE] |=> s_r.tx[$past(idx)] == $past(s_r.idata))
    else $error("indirect write lost data");

  unstable_set_a: assert property (
    rx.msgEnd && !rx.valid && !s_r.curSame && s_r.diffCnt >= stb_pkg::UNSTABLE_COUNT - 4'h1
      |=> s_r.un)
    else $error("unstable not raised after eight differing messages");

  mm_accept_a: assert property (
    acceptEvt |=> s_r.mm == !$past(s_r.curExp))
    else $error("mismatch bit wrong after acceptance");

  exp_read_a: assert property (
    s_r.state == stb_pkg::STB_ACC && s_r.iaddr[stb_pkg::IA_RW] && s_r.ctl[stb_pkg::CTL_RXSEL]
      && s_r.iaddr[stb_pkg::IA_PAGE] |=> s_r.idata == $past(s_r.exp[idx]))
    else $error("expected page read returned wrong byte");

  tx_read_a: assert property (
    s_r.state == stb_pkg::STB_ACC && s_r.iaddr[stb_pkg::IA_RW] && !s_r.ctl[stb_pkg::CTL_RXSEL]
      && !s_r.iaddr[stb_pkg::IA_PAGE] |=> s_r.idata == $past(s_r.tx[idx]))
    else $error("transmit buffer read returned wrong byte");

  cap_write_a: assert property (
    rx.valid |=> s_r.cap[$past(s_r.capIdx)] == $past(rx.data))
    else $error("received byte not captured");

  busy_stat_a: assert property (
    stRd |=> regRdData[7] == $past(s_r.busy))
    else $error("status read lost busy bit");

  un_irq_a: assert property (
    s_r.unFlag && s_r.ctl[stb_pkg::CTL_UNIE] |-> !irq_out_n)
    else $error("interrupt not asserted for unstable flag");

  idata_rd_a: assert property (
    bus.rd && bus.addr == stb_pkg::IDATA_ADDR |=> regRdData == $past(s_r.idata))
    else $error("data register read returned wrong byte");

  tx_page_skip_a: assert property (
    s_r.state == stb_pkg::STB_ACC && !s_r.iaddr[stb_pkg::IA_RW] && !s_r.ctl[stb_pkg::CTL_RXSEL]
      && s_r.iaddr[stb_pkg::IA_PAGE] |=> s_r.tx == $past(s_r.tx))
    else $error("write to unused transmit range changed buffer");

  cover_read_c: cover property (accessEvt && s_r.iaddr[stb_pkg::IA_RW]);
  cover_unstable_c: cover property ($rose(s_r.un));
  cover_mismatch_c: cover property ($rose(s_r.mm) ##[1:20] stRd);
  cover_write_c: cover property (accessEvt && !s_r.iaddr[stb_pkg::IA_RW]);
  cover_stable_c: cover property ($fell(s_r.un));

endmodule // stb_trace_access

`default_nettype wire

/* src/stb_pkg.sv */
/*
 * Constants and types for the section trace status and indirect buffer access block.
 * Assumes a host port with synchronous one-cycle read and write strobes on mclk.
 */
`default_nettype none

package stb_pkg;

  // ************************************************
  // Register offsets on the parallel register port
  // ************************************************
  localparam logic [6:0] CTL_ADDR = 7'h38;
  localparam logic [6:0] STAT_ADDR = 7'h39;
  localparam logic [6:0] IADDR_ADDR = 7'h3a;
  localparam logic [6:0] IDATA_ADDR = 7'h3b;

  // ************************************************
  // Field positions and reset values
  // ************************************************
  localparam int CTL_LEN16 = 0;
  localparam int CTL_TNULL = 2;
  localparam int CTL_PERS = 3;
  localparam int CTL_MMIE = 4;
  localparam int CTL_UNIE = 5;
  localparam int CTL_RXSEL = 6;
  localparam logic [6:0] CTL_RESET = 7'h04;
  localparam int IA_RW = 7;
  localparam int IA_PAGE = 6;
  localparam logic [7:0] IADDR_RESET = 8'h00;
  localparam logic [7:0] IDATA_RESET = 8'h00;

  // ************************************************
  // Message handling counts
  // ************************************************
  localparam logic [2:0] PERSIST_LONG = 3'h5;
  localparam logic [2:0] PERSIST_SHORT = 3'h3;
  localparam logic [3:0] UNSTABLE_COUNT = 4'h8;
  localparam logic [5:0] SHORT_MSG_LAST = 6'h0f;

  // ************************************************
  // Types
  // ************************************************
  typedef enum logic [1:0] {
    STB_IDLE = 2'b01,
    STB_ACC = 2'b10
  } stb_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } stb_bus_s;

  typedef struct packed {
    logic valid;
    logic msgEnd;
    logic [7:0] data;
  } stb_rx_s;

  typedef struct packed {
    stb_state_e state;
    logic [6:0] ctl;
    logic [7:0] iaddr;
    logic [7:0] idata;
    logic busy;
    logic mm;
    logic mmFlag;
    logic un;
    logic unFlag;
    logic [7:0] rdData;
    logic [5:0] capIdx;
    logic curSame;
    logic curExp;
    logic [2:0] sameCnt;
    logic [3:0] diffCnt;
    logic [5:0] txIdx;
    logic [7:0] txByte;
    logic [63:0][7:0] cap;
    logic [63:0][7:0] exp;
    logic [63:0][7:0] tx;
  } stb_state_s;

endpackage : stb_pkg

`default_nettype wire

/* tb/stb_host_model.sv */
/*
 * Host processor model driving the trace block register port.
 * Assumes one-cycle strobes launched after a rising mclk edge.
 */
`default_nettype none

module stb_host_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Register port
  output var stb_pkg::stb_bus_s bus,
  input wire logic [7:0] regRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  int timeouts = 0;
  initial bus = '0;
  // ************
  // Bus cycles
  // ************
  // Released address and data show the inverse
  task automatic cyc(input logic w, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk);
    bus <= {w, ~w, a, d};
    @(posedge mclk);
    bus <= {2'b00, ~a, ~d};
    @(posedge mclk);
    #1 q = regRdData;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    cyc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] q);
    cyc(1'b0, a, 8'h00, q);
  endtask
  // Address write, then status read on the next edge
  task automatic probe(input logic [7:0] ia, output logic [7:0] q);
    @(posedge mclk);
    bus <= {2'b10, stb_pkg::IADDR_ADDR, ia};
    @(posedge mclk);
    bus <= {2'b01, stb_pkg::STAT_ADDR, 8'h00};
    @(posedge mclk);
    bus <= {2'b00, ~stb_pkg::STAT_ADDR, 8'hff};
    @(posedge mclk);
    #1 q = regRdData;
  endtask
  task automatic waitIdle();
    logic [7:0] s;
    s = 8'hff;
    for (int i = 0; i < 20 && s[7] !== 1'b0; i++) rd(stb_pkg::STAT_ADDR, s);
    if (s[7] !== 1'b0) timeouts++;
  endtask
  task automatic iwr(input logic [6:0] idx, input logic [7:0] d);
    wr(stb_pkg::IDATA_ADDR, d);
    wr(stb_pkg::IADDR_ADDR, {1'b0, idx});
    waitIdle();
  endtask
  task automatic ird(input logic [6:0] idx, output logic [7:0] q);
    wr(stb_pkg::IADDR_ADDR, {1'b1, idx});
    waitIdle();
    rd(stb_pkg::IDATA_ADDR, q);
  endtask
endmodule // stb_host_model

`default_nettype wire

/* tb/tb.sv */
/*
 * Self-checking bench for the trace status and indirect access block.
 * Assumes the host model drives the register port; the bench drives the streams.
 */
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] ST = stb_pkg::STAT_ADDR;
  localparam logic [6:0] CT = stb_pkg::CTL_ADDR;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  stb_pkg::stb_bus_s bus;
  stb_pkg::stb_rx_s rx = '0;
  logic txJ0Req = 1'b0;
  logic [7:0] regRdData;
  logic [7:0] txJ0Byte;
  logic [7:0] q;
  logic irq_out_n;
  int nErrors = 0;
  int samplesChecked = 0;
  always #25 mclk = ~mclk;
  stb_trace_access dut (.mclk(mclk), .arst_n(arst_n), .bus(bus), .regRdData(regRdData), .rx(rx),
    .txJ0Req(txJ0Req), .txJ0Byte(txJ0Byte), .irq_out_n(irq_out_n));
  stb_host_model host (.mclk(mclk), .arst_n(arst_n), .bus(bus), .regRdData(regRdData));
  // ************
  // Helpers
  // ************
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      nErrors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Two-byte messages, each closed by an end pulse
  task automatic msg(input logic [7:0] b0, input logic [7:0] b1, input int n);
    repeat (n) begin
      @(posedge mclk) rx <= {2'b10, b0};
      @(posedge mclk) rx <= {2'b10, b1};
      @(posedge mclk) rx <= {2'b01, ~b1};
      @(posedge mclk) rx <= {2'b00, b0};
    end
    // Step past the closing edge so the evaluated state has settled
    #1;
  endtask
  task automatic printVerdict();
    nErrors += host.timeouts;
    $display("checks %0d mismatches %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ************
  // Scenarios
  // ************
  task automatic resetValues();
    host.rd(CT, q);
    check("ctl", q, {1'b0, stb_pkg::CTL_RESET});
    host.rd(ST, q);
    check("status", q, 8'h00);
    host.rd(stb_pkg::IADDR_ADDR, q);
    check("iaddr", q, 8'h00);
    host.rd(stb_pkg::IDATA_ADDR, q);
    check("idata", q, 8'h00);
    host.rd(7'h3c, q);
    check("unmapped", q, 8'h00);
    check("irq", {7'h00, irq_out_n}, 8'h01);
  endtask
  // Transmit side kept to indices below 64
  task automatic txBuffer();
    host.wr(CT, 8'h00);
    for (int i = 0; i < 3; i++) host.iwr(7'(i), 8'h31 + 8'(i));
    host.rd(stb_pkg::IADDR_ADDR, q);
    check("iaddr", q, 8'h02);
    host.probe(8'h81, q);
    check("busy", q & 8'h80, 8'h80);
    host.waitIdle();
    host.rd(stb_pkg::IDATA_ADDR, q);
    check("txread", q, 8'h32);
    @(posedge mclk) txJ0Req <= 1'b1;
    @(posedge mclk) txJ0Req <= 1'b0;
    @(posedge mclk);
    #1 check("j0", txJ0Byte, 8'h31);
    host.wr(CT, 8'h01);
    repeat (15) @(posedge mclk) txJ0Req <= 1'b1;
    @(posedge mclk) txJ0Req <= 1'b0;
    @(posedge mclk) txJ0Req <= 1'b1;
    @(posedge mclk) txJ0Req <= 1'b0;
    @(posedge mclk);
    #1 check("len16", txJ0Byte, 8'h31);
    host.wr(CT, 8'h05);
    @(posedge mclk) txJ0Req <= 1'b1;
    @(posedge mclk) txJ0Req <= 1'b0;
    @(posedge mclk);
    #1 check("tnull", txJ0Byte, 8'h00);
  endtask
  task automatic rxPages();
    host.wr(CT, 8'h50);
    host.iwr(7'h40, 8'haa);
    host.iwr(7'h41, 8'h55);
    host.ird(7'h41, q);
    check("expected", q, 8'h55);
    msg(8'h12, 8'h34, 1);
    host.ird(7'h01, q);
    check("capture", q, 8'h34);
  endtask
  task automatic mismatch();
    msg(8'haa, 8'h55, 3);
    host.rd(ST, q);
    check("match", q & 8'h03, 8'h00);
    msg(8'haa, 8'h56, 3);
    check("irqlow", {7'h00, irq_out_n}, 8'h00);
    host.wr(CT, 8'h40);
    check("irqmask", {7'h00, irq_out_n}, 8'h01);
    host.wr(CT, 8'h50);
    host.rd(ST, q);
    check("mm", q & 8'h03, 8'h03);
    check("irqhigh", {7'h00, irq_out_n}, 8'h01);
    host.rd(ST, q);
    check("mmclr", q & 8'h03, 8'h01);
    host.wr(CT, 8'h58);
    msg(8'haa, 8'h55, 4);
    host.rd(ST, q);
    check("per4", q & 8'h03, 8'h01);
    msg(8'haa, 8'h55, 1);
    host.rd(ST, q);
    check("persistence_select", q & 8'h03, 8'h02);
  endtask
  task automatic unstable();
    host.wr(CT, 8'h60);
    host.rd(ST, q);
    for (int i = 1; i < 8; i++) msg(8'(i), 8'h00, 1);
    host.rd(ST, q);
    check("un7", q & 8'h0c, 8'h00);
    msg(8'h08, 8'h00, 1);
    check("irqun", {7'h00, irq_out_n}, 8'h00);
    host.rd(ST, q);
    check("un8", q & 8'h0c, 8'h0c);
    msg(8'h08, 8'h00, 2);
    host.rd(ST, q);
    check("stable", q & 8'h0c, 8'h08);
  endtask
  initial begin
    #200us;
    nErrors++;
    printVerdict();
  end
  initial begin
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    resetValues();
    txBuffer();
    rxPages();
    mismatch();
    unstable();
    printVerdict();
  end
endmodule // tb

`default_nettype wire
